/* File: core/dcr_pkg.sv */
// Constants for the channel register set: port map, field positions, reset values
package dcr_pkg;
    // Register port width and channel count
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam int          NUM_CHANNELS    = 4;

    // Port map; offsets below 8 are channel address/count pairs
    localparam logic [3:0]  OFS_CHAN_TOP    = 4'h7;
    localparam logic [3:0]  OFS_CMD_STATUS  = 4'h8;
    localparam logic [3:0]  OFS_REQUEST     = 4'h9;
    localparam logic [3:0]  OFS_SINGLE_MASK = 4'hA;
    localparam logic [3:0]  OFS_MODE        = 4'hB;
    localparam logic [3:0]  OFS_BYTE_PTR    = 4'hC;
    localparam logic [3:0]  OFS_MCLR_TEMP   = 4'hD;
    localparam logic [3:0]  OFS_CLR_MASK    = 4'hE;
    localparam logic [3:0]  OFS_ALL_MASK    = 4'hF;

    // Command register fields
    localparam int          CMD_MEM2MEM_BIT = 0;
    localparam int          CMD_HOLD_BIT    = 1;

    // Stored six-bit mode fields (written byte bits 7:2)
    localparam int          MODE_AUTO_BIT   = 2;
    localparam int          MODE_DEC_BIT    = 3;

    // Request and single mask write fields
    localparam int          SEL_SET_BIT     = 2;

    // Reset and fill values
    localparam logic [7:0]  CMD_RESET       = 8'h00;
    localparam logic [3:0]  MASK_RESET      = 4'hF;
    localparam logic [3:0]  REQ_RESET       = 4'h0;
    localparam logic [5:0]  MODE_RESET      = 6'h00;
    localparam logic [7:0]  TEMP_RESET      = 8'h00;
    localparam logic [15:0] WORD_RESET      = 16'h0000;
    localparam logic [1:0]  MODE_READ_ONES  = 2'h3;
    localparam logic [3:0]  REQ_READ_ONES   = 4'hF;
    localparam logic [7:0]  UNDEF_READ      = 8'hFF;
    localparam logic [15:0] COUNT_LAST      = 16'h0000;
    localparam logic [15:0] WORD_STEP       = 16'h0001;
endpackage

/* File: core/dcr_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module dcr_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Raw pin level and filtered result
    input  wire logic [WIDTH-1:0] pin_level,
    output logic      [WIDTH-1:0] stable_level
);
    logic [WIDTH-1:0] stage1_reg;  // Metastability catch, read only by stage 2
    logic [WIDTH-1:0] stage2_reg;  // Second stage
    logic [WIDTH-1:0] stage3_reg;  // Third stage

    // Refuse a zero-width instance
    if (WIDTH < 1) begin : g_bad_width
        $error("dcr_sync needs WIDTH of at least one");
    end

    // Shift chain
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
            stage3_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= pin_level;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Per bit: accept a change only once stages 2 and 3 agree
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                stable_level[b] <= RESET_VALUE[b];
            end else if (stage2_reg[b] == stage3_reg[b]) begin
                stable_level[b] <= stage3_reg[b];
            end
        end
    end
endmodule

/* File: core/dcr_regs.sv */
// Four-channel DMA register set with byte-wide host port and special commands
`timescale 1ns/10ps
module dcr_regs #(
    parameter int CHANNELS = dcr_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Host I/O port pins
    input  wire logic        io_read_strobe_n,
    input  wire logic        io_write_strobe_n,
    input  wire logic [3:0]  io_address,
    input  wire logic [7:0]  system_data_lines_in,
    output logic      [7:0]  system_data_lines_out,
    output logic             system_data_lines_oe,
    // External request pins
    input  wire logic [3:0]  dreq,
    // Transfer engine events (same clock)
    input  wire logic        transfer_done,
    input  wire logic [1:0]  transfer_channel,
    input  wire logic        temp_capture,
    input  wire logic        temp_drive,
    // Settings and state for the transfer engine
    output logic [7:0]       command_setting,
    output logic [3:0]       request_mask,
    output logic [3:0]       service_request,
    output logic [15:0]      selected_address,
    output logic [5:0]       selected_mode,
    output logic             terminal_count_strobe,
    output logic [1:0]       terminal_count_channel
);
    // Only the two-bit channel fields are supported
    if (CHANNELS != dcr_pkg::NUM_CHANNELS) begin : g_bad_channels
        $error("dcr_regs supports exactly four channels");
    end

    // Synchronised pins
    logic        rd_n_s;                   // Filtered read strobe
    logic        wr_n_s;                   // Filtered write strobe
    logic [3:0]  addr_s;                   // Filtered port address
    logic [7:0]  data_s;                   // Filtered data lines
    logic [3:0]  dreq_s;                   // Filtered external requests
    logic        rd_n_prev_reg;            // Strobe history for edge detect
    logic        wr_n_prev_reg;

    // Register state
    logic [15:0] cur_addr_reg  [4];        // Current address per channel
    logic [15:0] cur_count_reg [4];        // Current word count per channel
    logic [15:0] base_addr_reg [4];        // Hidden base address
    logic [15:0] base_count_reg[4];        // Hidden base count
    logic [5:0]  mode_reg      [4];        // Mode bits 7:2 per channel
    logic [3:0]  tc_flag_reg;              // Status terminal count flags
    logic [3:0]  soft_req_reg;             // Software request bits
    logic        byte_ptr_reg;             // Zero: low byte next
    logic [1:0]  mode_cnt_reg;             // Mode read channel counter
    logic [7:0]  temp_reg;                 // Memory-to-memory holding byte
    logic [7:0]  rd_mux;                   // Read data selection

    // Decoded events
    logic        rd_evt;                   // One-cycle pulse, read asserted
    logic        wr_evt;                   // One-cycle pulse, write asserted
    logic        chan_access;              // Address or count register hit
    logic        mclr;                     // Master clear command
    logic [3:0]  tc_hit;                   // Wraparound on this channel
    logic [3:0]  host_wr_addr;             // Host writes channel address
    logic [3:0]  host_wr_count;            // Host writes channel count

    dcr_sync #(
        .WIDTH       (18),
        .RESET_VALUE ({2'b11, 16'h0000})
    ) u_pin_sync (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .pin_level    ({io_read_strobe_n, io_write_strobe_n, io_address,
                        system_data_lines_in, dreq}),
        .stable_level ({rd_n_s, wr_n_s, addr_s, data_s, dreq_s})
    );

    // Strobe history; address and data share the strobe's latency
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_n_prev_reg <= 1'b1;
            wr_n_prev_reg <= 1'b1;
        end else begin
            rd_n_prev_reg <= rd_n_s;
            wr_n_prev_reg <= wr_n_s;
        end
    end

    assign rd_evt      = rd_n_prev_reg & ~rd_n_s;
    assign wr_evt      = wr_n_prev_reg & ~wr_n_s;
    assign chan_access = (rd_evt | wr_evt) && (addr_s <= dcr_pkg::OFS_CHAN_TOP);
    assign mclr        = wr_evt && (addr_s == dcr_pkg::OFS_MCLR_TEMP);

    // Replace one byte of a word, chosen by the byte pointer
    function automatic logic [15:0] merge_byte(input logic [15:0] old_word,
                                               input logic [7:0]  new_byte,
                                               input logic        high);
        merge_byte = high ? {new_byte, old_word[7:0]} : {old_word[15:8], new_byte};
    endfunction

    // Per-channel address, count, mode, flag, mask and request logic
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        logic xfer;                        // Transfer completed on this channel
        logic auto_init;                   // Auto-initialize selected
        logic hold;                        // Address hold applies
        assign xfer              = transfer_done && (transfer_channel == 2'(ch));
        assign auto_init         = mode_reg[ch][dcr_pkg::MODE_AUTO_BIT];
        assign hold              = (ch == 0) && command_setting[dcr_pkg::CMD_HOLD_BIT];
        assign tc_hit[ch]        = xfer && (cur_count_reg[ch] == dcr_pkg::COUNT_LAST);
        assign host_wr_addr[ch]  = wr_evt && (addr_s == 4'(2 * ch));
        assign host_wr_count[ch] = wr_evt && (addr_s == 4'(2 * ch + 1));

        // Current and base address; host write wins over a transfer step
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                cur_addr_reg[ch]  <= dcr_pkg::WORD_RESET;
                base_addr_reg[ch] <= dcr_pkg::WORD_RESET;
            end else if (host_wr_addr[ch]) begin
                cur_addr_reg[ch]  <= merge_byte(cur_addr_reg[ch], data_s, byte_ptr_reg);
                base_addr_reg[ch] <= merge_byte(base_addr_reg[ch], data_s, byte_ptr_reg);
            end else if (tc_hit[ch] && auto_init) begin
                cur_addr_reg[ch]  <= base_addr_reg[ch];
            end else if (xfer && !hold) begin
                if (mode_reg[ch][dcr_pkg::MODE_DEC_BIT]) begin
                    cur_addr_reg[ch] <= cur_addr_reg[ch] - dcr_pkg::WORD_STEP;
                end else begin
                    cur_addr_reg[ch] <= cur_addr_reg[ch] + dcr_pkg::WORD_STEP;
                end
            end
        end

        // Current and base word count
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                cur_count_reg[ch]  <= dcr_pkg::WORD_RESET;
                base_count_reg[ch] <= dcr_pkg::WORD_RESET;
            end else if (host_wr_count[ch]) begin
                cur_count_reg[ch]  <= merge_byte(cur_count_reg[ch], data_s, byte_ptr_reg);
                base_count_reg[ch] <= merge_byte(base_count_reg[ch], data_s, byte_ptr_reg);
            end else if (tc_hit[ch] && auto_init) begin
                cur_count_reg[ch]  <= base_count_reg[ch];
            end else if (xfer) begin
                cur_count_reg[ch]  <= cur_count_reg[ch] - dcr_pkg::WORD_STEP;
            end
        end

        // Mode setting; master clear leaves modes alone
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                mode_reg[ch] <= dcr_pkg::MODE_RESET;
            end else if (wr_evt && (addr_s == dcr_pkg::OFS_MODE) && (data_s[1:0] == 2'(ch))) begin
                mode_reg[ch] <= data_s[7:2];
            end
        end

        // Terminal count flag: a new wrap beats a status-read clear
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                tc_flag_reg[ch] <= 1'b0;
            end else if (tc_hit[ch]) begin
                tc_flag_reg[ch] <= 1'b1;
            end else if (mclr || (rd_evt && (addr_s == dcr_pkg::OFS_CMD_STATUS))) begin
                tc_flag_reg[ch] <= 1'b0;
            end
        end

        // Request mask: wrap without auto-initialize beats host clears
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                request_mask[ch] <= dcr_pkg::MASK_RESET[ch];
            end else if (mclr || (tc_hit[ch] && !auto_init)) begin
                request_mask[ch] <= 1'b1;
            end else if (wr_evt && (addr_s == dcr_pkg::OFS_SINGLE_MASK)
                         && (data_s[1:0] == 2'(ch))) begin
                request_mask[ch] <= data_s[dcr_pkg::SEL_SET_BIT];
            end else if (wr_evt && (addr_s == dcr_pkg::OFS_ALL_MASK)) begin
                request_mask[ch] <= data_s[ch];
            end else if (wr_evt && (addr_s == dcr_pkg::OFS_CLR_MASK)) begin
                request_mask[ch] <= 1'b0;
            end
        end

        // Software request: a host set beats the clear at terminal count
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                soft_req_reg[ch] <= dcr_pkg::REQ_RESET[ch];
            end else if (mclr) begin
                soft_req_reg[ch] <= 1'b0;
            end else if (wr_evt && (addr_s == dcr_pkg::OFS_REQUEST)
                         && (data_s[1:0] == 2'(ch))) begin
                soft_req_reg[ch] <= data_s[dcr_pkg::SEL_SET_BIT];
            end else if (tc_hit[ch]) begin
                soft_req_reg[ch] <= 1'b0;
            end
        end

        // Service request: software requests ignore the mask
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                service_request[ch] <= 1'b0;
            end else begin
                service_request[ch] <= (dreq_s[ch] & ~request_mask[ch]) | soft_req_reg[ch];
            end
        end
    end

    // Command register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            command_setting <= dcr_pkg::CMD_RESET;
        end else if (mclr) begin
            command_setting <= dcr_pkg::CMD_RESET;
        end else if (wr_evt && (addr_s == dcr_pkg::OFS_CMD_STATUS)) begin
            command_setting <= data_s;
        end
    end

    // Byte pointer; commands take the pointer without using the data lines
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            byte_ptr_reg <= 1'b0;
        end else if (mclr || (wr_evt && (addr_s == dcr_pkg::OFS_BYTE_PTR))) begin
            byte_ptr_reg <= 1'b0;
        end else if (rd_evt && (addr_s == dcr_pkg::OFS_BYTE_PTR)) begin
            byte_ptr_reg <= 1'b1;
        end else if (chan_access) begin
            byte_ptr_reg <= ~byte_ptr_reg;
        end
    end

    // Mode read counter, wraps after channel 3
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_cnt_reg <= 2'h0;
        end else if (mclr || (rd_evt && (addr_s == dcr_pkg::OFS_CLR_MASK))) begin
            mode_cnt_reg <= 2'h0;
        end else if (rd_evt && (addr_s == dcr_pkg::OFS_MODE)) begin
            mode_cnt_reg <= mode_cnt_reg + 2'h1;
        end
    end

    // Temporary register keeps the last captured byte
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            temp_reg <= dcr_pkg::TEMP_RESET;
        end else if (mclr) begin
            temp_reg <= dcr_pkg::TEMP_RESET;
        end else if (temp_capture) begin
            temp_reg <= data_s;
        end
    end

    // Read data selection
    always_comb begin
        rd_mux = dcr_pkg::UNDEF_READ;  // Special command reads are undefined
        if (addr_s <= dcr_pkg::OFS_CHAN_TOP) begin
            if (addr_s[0]) begin
                rd_mux = byte_ptr_reg ? cur_count_reg[addr_s[2:1]][15:8]
                                      : cur_count_reg[addr_s[2:1]][7:0];
            end else begin
                rd_mux = byte_ptr_reg ? cur_addr_reg[addr_s[2:1]][15:8]
                                      : cur_addr_reg[addr_s[2:1]][7:0];
            end
        end else begin
            case (addr_s)
                dcr_pkg::OFS_CMD_STATUS: rd_mux = {dreq_s, tc_flag_reg};
                dcr_pkg::OFS_REQUEST:    rd_mux = {dcr_pkg::REQ_READ_ONES, soft_req_reg};
                dcr_pkg::OFS_MODE:       rd_mux = {mode_reg[mode_cnt_reg], dcr_pkg::MODE_READ_ONES};
                dcr_pkg::OFS_MCLR_TEMP:  rd_mux = temp_reg;
                default:                 rd_mux = dcr_pkg::UNDEF_READ;
            endcase
        end
    end

    // Data bus drive: memory-to-memory write cycle, else host read
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            system_data_lines_out <= dcr_pkg::TEMP_RESET;
            system_data_lines_oe  <= 1'b0;
        end else begin
            system_data_lines_oe <= temp_drive | ~rd_n_s;
            if (temp_drive) begin
                system_data_lines_out <= temp_reg;
            end else if (rd_evt) begin
                system_data_lines_out <= rd_mux;
            end
        end
    end

    // Terminal count pulse and selected channel view for the engine
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            terminal_count_strobe  <= 1'b0;
            terminal_count_channel <= 2'h0;
            selected_address       <= dcr_pkg::WORD_RESET;
            selected_mode          <= dcr_pkg::MODE_RESET;
        end else begin
            terminal_count_strobe  <= |tc_hit;
            terminal_count_channel <= transfer_channel;
            selected_address       <= cur_addr_reg[transfer_channel];
            selected_mode          <= mode_reg[transfer_channel];
        end
    end
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_mclr_masks_set: assert property (mclr |=> request_mask == 4'hF)
        else $error("mask not set after master clear");
    chk_mclr_cmd_zero: assert property (mclr |=> command_setting == 8'h00 && !byte_ptr_reg
                                        && mode_cnt_reg == 2'h0)
        else $error("master clear left state");
    chk_req_read_ones: assert property (rd_evt && addr_s == dcr_pkg::OFS_REQUEST && !temp_drive
                                        |=> system_data_lines_out == {4'hF, $past(soft_req_reg)})
        else $error("request read wrong");
    chk_mode_read_low: assert property (rd_evt && addr_s == dcr_pkg::OFS_MODE && !temp_drive
                                        |=> system_data_lines_out[1:0] == 2'h3
                                        && mode_cnt_reg == $past(mode_cnt_reg) + 2'h1)
        else $error("mode read wrong");
    chk_ptr_toggle: assert property (chan_access |=> byte_ptr_reg != $past(byte_ptr_reg))
        else $error("byte pointer did not toggle");
    chk_tc_pulse: assert property (transfer_done && tc_hit == 4'h0 |=> !terminal_count_strobe)
        else $error("spurious terminal count");
    chk_tc_wrap: assert property (tc_hit[3] && !host_wr_count[3] && !g_chan[3].auto_init
                                  |=> terminal_count_strobe && request_mask[3]
                                  && cur_count_reg[3] == 16'hFFFF)
        else $error("wrap did not end channel 3");
    chk_auto_reload: assert property (tc_hit[2] && g_chan[2].auto_init && !host_wr_count[2]
                                      |=> cur_count_reg[2] == $past(base_count_reg[2]))
        else $error("auto-initialize reload missed");
    chk_hold_chan0: assert property (g_chan[0].xfer && g_chan[0].hold && !tc_hit[0]
                                     && !host_wr_addr[0]
                                     |=> $stable(cur_addr_reg[0]))
        else $error("held address moved");
    chk_base_follows: assert property (host_wr_addr[3] && !byte_ptr_reg
                                       |=> base_addr_reg[3][7:0] == $past(data_s))
        else $error("base address not loaded");
    chk_clear_mask: assert property (wr_evt && addr_s == dcr_pkg::OFS_CLR_MASK && tc_hit == 4'h0
                                     |=> request_mask == 4'h0)
        else $error("clear mask failed");

    cov_auto_init: cover property (tc_hit[0] && g_chan[0].auto_init);
    cov_mode_sweep: cover property (rd_evt && addr_s == dcr_pkg::OFS_MODE && mode_cnt_reg == 2'h3);
    cov_mem2mem: cover property (temp_capture ##[1:8] temp_drive);
    cov_mclr: cover property (mclr);
endmodule

/* File: sim/dcr_host.sv */
// Host processor model issuing byte-wide I/O cycles on the strobe pins
`timescale 1ns/10ps
module dcr_host (
    // Clock and read-back data
    input  wire logic       core_clk,
    input  wire logic [7:0] rdata,
    // Host pins
    output logic            rd_n,
    output logic            wr_n,
    output logic [3:0]      addr,
    output logic [7:0]      wdata
);
    // Idle pins at time zero
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
    end
    // One byte cycle; address leads strobe by a cycle, strobe held long for sync path
    task automatic cycle(input logic w, input logic [3:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        @(negedge core_clk);
        addr = a;
        wdata = d;
        @(negedge core_clk);
        wr_n = !w;
        rd_n = w;
        repeat (8) @(negedge core_clk);
        q = rdata;
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the channel register set
`timescale 1ns/10ps
module tb_top;
    logic        core_clk = 1'b0, resetn = 1'b0, done = 1'b0, rd_n, wr_n, oe, tcs;
    logic        cap = 1'b0, drv = 1'b0, mem_drv = 1'b0;
    logic [1:0]  ch = 2'h0, tcc, tc_ch = 2'h0;
    logic [3:0]  a, dreq = 4'h0, mask, srq;
    logic [5:0]  smode;
    logic [7:0]  wd, dout, cmd, q, mem_byte = 8'h5A;
    logic [15:0] sel;
    int          errors = 0, cmp_count = 0, cyc = 0, tc_seen = 0;
    // Memory model drives a mem-to-mem read; a released bus shows the inverse host byte
    wire  [7:0]  sd = oe ? dout : mem_drv ? mem_byte : (!wr_n ? wd : ~wd);
    always #12.5 core_clk = ~core_clk;
    dcr_host i_host (.core_clk(core_clk), .rdata(dout), .rd_n(rd_n), .wr_n(wr_n),
                     .addr(a), .wdata(wd));
    dcr_regs i_dut (.core_clk(core_clk), .resetn(resetn), .io_read_strobe_n(rd_n),
        .io_write_strobe_n(wr_n), .io_address(a), .system_data_lines_in(sd),
        .system_data_lines_out(dout), .system_data_lines_oe(oe), .dreq(dreq),
        .transfer_done(done), .transfer_channel(ch), .temp_capture(cap),
        .temp_drive(drv), .command_setting(cmd), .request_mask(mask),
        .service_request(srq), .selected_address(sel), .selected_mode(smode),
        .terminal_count_strobe(tcs), .terminal_count_channel(tcc));
    // Cycle ceiling and terminal count pulse tally
    always @(posedge core_clk) begin
        cyc++;
        if (tcs) begin
            tc_seen++;
            tc_ch = tcc;
        end
        if (cyc == 5000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        i_host.cycle(1'b1, ad, d, q);
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        i_host.cycle(1'b0, ad, 8'hFF, q);
        chk(q, e);
    endtask
    // Transfer pulses on one channel, then time for the registered views to settle
    task automatic run_xfer(input logic [1:0] c, input int n);
        @(negedge core_clk);
        ch = c;
        done = 1'b1;
        repeat (n) @(negedge core_clk);
        done = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic t_reset();
        chk(cmd, 8'h00);
        chk(mask, 4'hF);
        rd(4'h9, 8'hF0);
        $display("test reset ended");
    endtask
    task automatic t_addr();
        wr(4'hC, 8'h55);
        wr(4'h0, 8'h34);
        wr(4'h0, 8'h12);
        wr(4'hC, 8'h00);
        rd(4'h0, 8'h34);
        wr(4'hC, 8'h00);
        rd(4'hC, 8'hFF);
        rd(4'h0, 8'h12);
        $display("test byte pointer ended");
    endtask
    task automatic t_mode();
        for (int i = 0; i < 4; i++) wr(4'hB, {6'(i + 5), 2'(i)});
        rd(4'hB, 8'h17);
        rd(4'hE, 8'hFF);
        for (int i = 0; i < 4; i++) rd(4'hB, {6'(i + 5), 2'h3});
        $display("test mode ended");
    endtask
    task automatic t_wrap();
        wr(4'hC, 8'h00);
        wr(4'h6, 8'h10);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h01);
        wr(4'h7, 8'h00);
        wr(4'hE, 8'hAA);
        chk(mask, 4'h0);
        run_xfer(2'h3, 2);
        chk(tc_seen, 1);
        chk(tc_ch, 2'h3);
        chk(mask, 4'h8);
        chk(sel, 16'h000E);
        rd(4'h8, 8'h08);
        rd(4'h7, 8'hFF);
        $display("test wrap ended");
    endtask
    // Channel 2 runs with auto-initialize: reload, keep mask clear
    task automatic t_auto();
        wr(4'hC, 8'h00);
        wr(4'h4, 8'h20);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h01);
        wr(4'h5, 8'h00);
        run_xfer(2'h2, 2);
        chk(tc_seen, 2);
        chk(tc_ch, 2'h2);
        chk(sel, 16'h0020);
        chk(smode, 6'h07);
        chk(mask, 4'h8);
        rd(4'h5, 8'h01);
        $display("test auto-initialize ended");
    endtask
    // Memory-to-memory: capture a byte from the bus, then drive it back
    task automatic t_temp();
        @(negedge core_clk) mem_drv = 1'b1;
        repeat (6) @(negedge core_clk);
        cap = 1'b1;
        @(negedge core_clk);
        {cap, mem_drv, drv} = 3'b001;
        @(negedge core_clk);
        chk({oe, dout}, 9'h15A);
        drv = 1'b0;
        rd(4'hD, 8'h5A);
        $display("test temporary register ended");
    endtask
    task automatic t_mclr();
        wr(4'h8, 8'h02);
        chk(cmd, 8'h02);
        wr(4'hC, 8'h00);
        wr(4'h1, 8'h05);
        wr(4'h1, 8'h00);
        run_xfer(2'h0, 2);
        chk(sel, 16'h1234);
        rd(4'h1, 8'h03);
        wr(4'h9, 8'h07);
        rd(4'hB, 8'h17);
        wr(4'hD, 8'h77);
        chk(cmd, 8'h00);
        chk(mask, 4'hF);
        rd(4'h6, 8'h0E);
        rd(4'hB, 8'h17);
        rd(4'h9, 8'hF0);
        rd(4'h8, 8'h00);
        rd(4'hD, 8'h00);
        $display("test master clear ended");
    endtask
    // External requests against single and all-mask writes, software bypass
    task automatic t_mask();
        dreq = 4'hF;
        wr(4'hF, 8'h0A);
        chk(mask, 4'hA);
        chk(srq, 4'h5);
        wr(4'hA, 8'h04);
        chk(mask, 4'hB);
        wr(4'h9, 8'h07);
        chk(srq, 4'hC);
        rd(4'h9, 8'hF8);
        rd(4'h8, 8'hF0);
        $display("test mask ended");
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) resetn = 1'b1;
        repeat (6) @(negedge core_clk);
        t_reset();
        t_addr();
        t_mode();
        t_wrap();
        t_auto();
        t_temp();
        t_mclr();
        t_mask();
        give_verdict();
    end
endmodule
